// ===== pft_pkg.sv
package pft_pkg;
   localparam int PC_WIDTH_16K   = 14;
   localparam int PC_WIDTH_32K   = 15;
   localparam int BANK_LOW_BIT   = 13;
   localparam int PAGE_BITS      = 8;
   localparam int STACK_DEPTH    = 16;
   localparam int RESET_VECTOR   = 0;
   localparam int DATA_WIDTH     = 8;
   localparam int WORD_WIDTH     = 16;
   localparam int TABLE_CYCLES   = 2;
   localparam logic [1:0] TBL_CURRENT_PAGE = 2'h0;
   localparam logic [1:0] TBL_LONG         = 2'h1;
   localparam logic [1:0] TBL_LAST_PAGE    = 2'h2;

   typedef enum logic [1:0] {
      PFT_RUN,
      PFT_IDLE,
      PFT_TABLE
   } pft_state_t;
endpackage

// ===== pft_prog_mem.sv
// Program memory model; the word follows the registered fetch address within the same cycle.
// Contents are a fixed function of the address.
module pft_prog_mem #(
   parameter int PC_W = 14
) (
   input  wire logic [PC_W-1:0] progAddr,
   output logic      [15:0]     progData
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      progData = {progAddr[7:0] ^ 8'h3C, progAddr[13:6]};
   end
endmodule

// ===== pft_program_flow.sv
// Summary of operation
// - Jump, call, interrupt entry and reset load a target instead of incrementing.
// - A taken skip discards the prefetched word and runs an idle cycle.
// - Writing the low program counter byte replaces bits 7..0 only, same page.
// - A low byte write acts as a branch with one idle prefetch cycle.
// - The return stack holds only counter values and has no software access.
// - Call and interrupt acknowledge push the return address.
// - Subroutine and interrupt returns pop the stack into the counter.
// - Reset points the stack pointer at the empty top.
// - With the stack full an interrupt waits until a return pops.
// - A call with the stack full proceeds and loses the oldest entry.
// - Arithmetic results go to the destination with carry or borrow updated.
// - Bank pointer bit 0, or bits 1..0, select the program memory bank.
// - After reset fetching starts at address zero.
// - Table pointer high and low bytes form the long table address.
// - A short table read offsets from the current page start, or from the last page start in last-page mode.
// - A table read sends the low byte out and latches the high byte.
// - The table high latch changes only through a table read.
// - Every table read takes two instruction cycles.
// - Otherwise the counter advances by one per executed instruction.
// - Counter-changing instructions take one extra instruction cycle.
module pft_program_flow #(
   parameter int PC_W  = pft_pkg::PC_WIDTH_16K,
   parameter int DEPTH = pft_pkg::STACK_DEPTH
) (
   input  wire logic                              mclk,
   input  wire logic                              reset,
   input  wire logic                              opJump,
   input  wire logic                              opCall,
   input  wire logic                              opReturn,
   input  wire logic                              opSkipTaken,
   input  wire logic                              opPcLowWrite,
   input  wire logic                              opTableRead,
   input  wire logic                              opAlu,
   input  wire logic [1:0]                        tableMode,
   input  wire logic [pft_pkg::BANK_LOW_BIT-1:0]  jumpOffset,
   input  wire logic [PC_W-pft_pkg::BANK_LOW_BIT-1:0] bankPointer,
   input  wire logic [pft_pkg::DATA_WIDTH-1:0]    pcLowWriteData,
   input  wire logic [pft_pkg::DATA_WIDTH-1:0]    tablePointerLow,
   input  wire logic [PC_W-pft_pkg::PAGE_BITS-1:0] tablePointerHigh,
   input  wire logic                              aluSubtract,
   input  wire logic [pft_pkg::DATA_WIDTH-1:0]    aluOperandA,
   input  wire logic [pft_pkg::DATA_WIDTH-1:0]    aluOperandB,
   input  wire logic                              intRequest,
   input  wire logic [PC_W-1:0]                   intVector,
   input  wire logic [pft_pkg::WORD_WIDTH-1:0]    progData,
   output logic [PC_W-1:0]                        pc,
   output logic [PC_W-1:0]                        progAddr,
   output logic                                   issueReady,
   output logic                                   dummyCycle,
   output logic                                   intAck,
   output logic                                   stackFull,
   output logic                                   stackEmpty,
   output logic [pft_pkg::DATA_WIDTH-1:0]         tableLowData,
   output logic                                   tableLowValid,
   output logic [pft_pkg::DATA_WIDTH-1:0]         table_high_latch,
   output logic [pft_pkg::DATA_WIDTH-1:0]         aluResult,
   output logic                                   aluCarry
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [IW-1:0] LAST_INDEX = IW'(DEPTH - 1);

   function automatic logic [PC_W-1:0] pageAddr(input logic [PC_W-pft_pkg::PAGE_BITS-1:0] page,
                                               input logic [pft_pkg::DATA_WIDTH-1:0]       low);
      pageAddr = {page, low};
   endfunction

   pft_pkg::pft_state_t state;
   pft_pkg::pft_state_t next_state;
   logic [PC_W-1:0] stackMem [DEPTH];
   logic [IW-1:0]   stackTop;
   logic [CW-1:0]   stackCount;

   wire logic            running     = (state == pft_pkg::PFT_RUN);
   wire logic            takeInt     = running && intRequest && !stackFull;
   wire logic            execute     = running && !takeInt;
   wire logic            doCall      = execute && opCall;
   wire logic            doJump      = execute && opJump;
   wire logic            doReturn    = execute && opReturn && !opCall && !opJump;
   wire logic            doSkip      = execute && opSkipTaken;
   wire logic            doPcWrite   = execute && opPcLowWrite;
   wire logic            doTable     = execute && opTableRead && !opCall && !opJump && !opReturn && !opPcLowWrite
                                       && !opSkipTaken;
   wire logic            doPush      = takeInt || doCall;
   wire logic            doPop       = doReturn && !stackEmpty;
   wire logic [IW-1:0]   pushIndex   = (stackTop == LAST_INDEX) ? '0 : stackTop + 1'b1;
   wire logic [IW-1:0]   popIndex    = (stackTop == '0) ? LAST_INDEX : stackTop - 1'b1;
   wire logic [PC_W-1:0] pcPlusOne   = pc + 1'b1;
   wire logic [PC_W-1:0] pcPlusTwo   = pc + 2'd2;
   wire logic [PC_W-1:0] bankTarget  = {bankPointer, jumpOffset};
   wire logic [PC_W-pft_pkg::PAGE_BITS-1:0] curPage = pc[PC_W-1:pft_pkg::PAGE_BITS];
   wire logic [PC_W-pft_pkg::PAGE_BITS-1:0] lastPage = '1;
   wire logic [PC_W-1:0] tableAddr   =
      (tableMode == pft_pkg::TBL_LONG)      ? pageAddr(tablePointerHigh, tablePointerLow) :
      (tableMode == pft_pkg::TBL_LAST_PAGE) ? pageAddr(lastPage, tablePointerLow) :
                                              pageAddr(curPage, tablePointerLow);
   wire logic [pft_pkg::DATA_WIDTH:0] aluSum = aluSubtract ?
      {1'b0, aluOperandA} - {1'b0, aluOperandB} : {1'b0, aluOperandA} + {1'b0, aluOperandB};

   logic [PC_W-1:0] next_pc;
   always_comb begin
      next_pc    = pc;
      next_state = state;
      case (state)
         pft_pkg::PFT_RUN: begin
            if (takeInt) begin
               next_pc    = intVector;
               next_state = pft_pkg::PFT_IDLE;
            end else if (doCall || doJump) begin
               next_pc    = bankTarget;
               next_state = pft_pkg::PFT_IDLE;
            end else if (doReturn) begin
               next_pc    = stackMem[stackTop];
               next_state = pft_pkg::PFT_IDLE;
            end else if (doPcWrite) begin
               next_pc    = pageAddr(curPage, pcLowWriteData);
               next_state = pft_pkg::PFT_IDLE;
            end else if (doSkip) begin
               next_pc    = pcPlusTwo;
               next_state = pft_pkg::PFT_IDLE;
            end else if (doTable) begin
               next_pc    = pcPlusOne;
               next_state = pft_pkg::PFT_TABLE;
            end else begin
               next_pc    = pcPlusOne;
            end
         end
         pft_pkg::PFT_IDLE:  next_state = pft_pkg::PFT_RUN;
         pft_pkg::PFT_TABLE: next_state = pft_pkg::PFT_RUN;
         default:            next_state = pft_pkg::PFT_RUN;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state    <= pft_pkg::PFT_RUN;
         pc       <= PC_W'(pft_pkg::RESET_VECTOR);
         progAddr <= PC_W'(pft_pkg::RESET_VECTOR);
      end else begin
         state    <= next_state;
         pc       <= next_pc;
         progAddr <= doTable ? tableAddr : next_pc;
      end
   end

   // The stack is a ring: an overflowing push overwrites the oldest slot.
   always_ff @(posedge mclk) begin
      if (doPush) begin
         stackMem[pushIndex] <= takeInt ? pc : pcPlusOne;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         stackTop   <= LAST_INDEX;
         stackCount <= '0;
      end else if (doPush) begin
         stackTop   <= pushIndex;
         stackCount <= stackFull ? stackCount : stackCount + 1'b1;
      end else if (doPop) begin
         stackTop   <= popIndex;
         stackCount <= stackCount - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         stackFull  <= 1'b0;
         stackEmpty <= 1'b1;
      end else if (doPush) begin
         stackFull  <= (stackCount >= FULL_COUNT - 1'b1);
         stackEmpty <= 1'b0;
      end else if (doPop) begin
         stackFull  <= 1'b0;
         stackEmpty <= (stackCount == CW'(1));
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         issueReady <= 1'b1;
         dummyCycle <= 1'b0;
         intAck     <= 1'b0;
      end else begin
         issueReady <= (next_state == pft_pkg::PFT_RUN);
         dummyCycle <= (next_state == pft_pkg::PFT_IDLE);
         intAck     <= takeInt;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         tableLowData     <= '0;
         tableLowValid    <= 1'b0;
         table_high_latch <= '0;
      end else begin
         tableLowValid <= (state == pft_pkg::PFT_TABLE);
         if (state == pft_pkg::PFT_TABLE) begin
            tableLowData     <= progData[pft_pkg::DATA_WIDTH-1:0];
            table_high_latch <= progData[pft_pkg::WORD_WIDTH-1:pft_pkg::DATA_WIDTH];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         aluResult <= '0;
         aluCarry  <= 1'b0;
      end else if (execute && opAlu) begin
         aluResult <= aluSum[pft_pkg::DATA_WIDTH-1:0];
         aluCarry  <= aluSubtract ? !aluSum[pft_pkg::DATA_WIDTH] : aluSum[pft_pkg::DATA_WIDTH];
      end
   end

   sequence tableIssue;
      running && !intRequest && opTableRead && !opCall && !opJump && !opReturn && !opPcLowWrite
         && !opSkipTaken;
   endsequence
   sequence tableDone;
      !issueReady ##1 issueReady && tableLowValid;
   endsequence

   jump_target_a: assert property (@(posedge mclk) disable iff (reset)
      doJump |=> pc == $past(bankTarget) && dummyCycle)
      else $error("jump did not load target");
   skip_idle_a: assert property (@(posedge mclk) disable iff (reset)
      doSkip && !doCall && !doJump && !doReturn && !doPcWrite |=> pc == $past(pcPlusTwo) && dummyCycle)
      else $error("skip did not discard prefetch");
   pc_low_page_a: assert property (@(posedge mclk) disable iff (reset)
      doPcWrite && !doCall && !doJump && !doReturn |=> pc[PC_W-1:8] == $past(curPage)
         && pc[7:0] == $past(pcLowWriteData) ##1 issueReady)
      else $error("low byte write left page");
   pc_write_idle_a: assert property (@(posedge mclk) disable iff (reset)
      doPcWrite |=> dummyCycle && !issueReady)
      else $error("low byte write without idle cycle");
   call_return_a: assert property (@(posedge mclk) disable iff (reset)
      doCall && !stackFull ##2 issueReady && opReturn && !opCall && !opJump && !intRequest
         |=> pc == $past(pc, 3) + 1'b1)
      else $error("return did not restore counter");
   reset_stack_a: assert property (@(posedge mclk)
      reset |=> stackEmpty && !stackFull && pc == '0)
      else $error("reset state wrong");
   int_block_a: assert property (@(posedge mclk) disable iff (reset)
      stackFull |=> !intAck)
      else $error("interrupt taken with stack full");
   overflow_full_a: assert property (@(posedge mclk) disable iff (reset)
      doCall && stackFull |=> stackFull && dummyCycle)
      else $error("overflowing call misbehaved");
   table_two_a: assert property (@(posedge mclk) disable iff (reset)
      tableIssue |=> tableDone)
      else $error("table read not two cycles");
   latch_hold_a: assert property (@(posedge mclk) disable iff (reset)
      state != pft_pkg::PFT_TABLE |=> $stable(table_high_latch))
      else $error("table latch changed without read");
   pc_step_a: assert property (@(posedge mclk) disable iff (reset)
      execute && !opCall && !opJump && !opReturn && !opPcLowWrite && !opSkipTaken && !opTableRead
         |=> pc == $past(pcPlusOne) && issueReady)
      else $error("counter did not advance by one");

   // Interrupt entry acknowledges for one cycle and idles once before the next issue.
   sequence intEntry;
      intAck && dummyCycle && !issueReady ##1 !intAck && issueReady;
   endsequence

   int_entry_a: assert property (@(posedge mclk) disable iff (reset)
      takeInt |=> pc == $past(intVector) ##0 intEntry)
      else $error("interrupt entry wrong");
   bank_select_a: assert property (@(posedge mclk) disable iff (reset)
      doJump |=> pc[PC_W-1:pft_pkg::BANK_LOW_BIT] == $past(bankPointer))
      else $error("jump ignored bank pointer");
   idle_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !running |=> $stable(pc))
      else $error("counter moved in idle cycle");
   reset_fetch_a: assert property (@(posedge mclk)
      reset |=> progAddr == '0 && issueReady && !dummyCycle && !intAck)
      else $error("fetch not at reset vector");

   // The slot just written must hold the return address of the push that wrote it.
   call_push_a: assert property (@(posedge mclk) disable iff (reset)
      doCall |=> stackMem[$past(pushIndex)] == $past(pcPlusOne))
      else $error("call pushed wrong address");
   int_push_a: assert property (@(posedge mclk) disable iff (reset)
      takeInt |=> stackMem[$past(pushIndex)] == $past(pc))
      else $error("interrupt pushed wrong address");
   return_pop_a: assert property (@(posedge mclk) disable iff (reset)
      doPop |=> pc == $past(stackMem[stackTop]) && dummyCycle)
      else $error("return loaded wrong address");
   stack_count_a: assert property (@(posedge mclk) disable iff (reset)
      stackFull == (stackCount == FULL_COUNT) && stackEmpty == (stackCount == '0))
      else $error("stack flags disagree with count");
   long_table_a: assert property (@(posedge mclk) disable iff (reset)
      doTable && tableMode == pft_pkg::TBL_LONG |=> progAddr == $past({tablePointerHigh, tablePointerLow}))
      else $error("long table address wrong");
   page_table_a: assert property (@(posedge mclk) disable iff (reset)
      doTable && tableMode == pft_pkg::TBL_CURRENT_PAGE
         |=> progAddr == {$past(pc[PC_W-1:pft_pkg::PAGE_BITS]), $past(tablePointerLow)})
      else $error("page table address wrong");
   table_data_a: assert property (@(posedge mclk) disable iff (reset)
      state == pft_pkg::PFT_TABLE |=> tableLowValid && tableLowData == $past(progData[pft_pkg::DATA_WIDTH-1:0])
         && table_high_latch == $past(progData[pft_pkg::WORD_WIDTH-1:pft_pkg::DATA_WIDTH]))
      else $error("table word split wrong");
   alu_add_a: assert property (@(posedge mclk) disable iff (reset)
      execute && opAlu && !aluSubtract |=> {aluCarry, aluResult} == $past({1'b0, aluOperandA} + {1'b0, aluOperandB}))
      else $error("addition result wrong");
   alu_sub_a: assert property (@(posedge mclk) disable iff (reset)
      execute && opAlu && aluSubtract |=> aluResult == $past(aluOperandA - aluOperandB)
         && aluCarry == $past(aluOperandA >= aluOperandB))
      else $error("subtraction result wrong");
endmodule

// ===== test_program_flow_and_table_read.sv
module test_program_flow_and_table_read;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] J = 7'h40, C = 7'h20, R = 7'h10, S = 7'h08, W = 7'h04, T = 7'h02, A = 7'h01;
   logic        mclk = 1'b0, reset = 1'b1, aluSubtract = 1'b0, intRequest = 1'b0;
   logic [6:0]  ops = 7'h00;
   logic [1:0]  tableMode = 2'h0;
   logic [12:0] jumpOffset = 13'h0000;
   logic [0:0]  bankPointer = 1'b0;
   logic [7:0]  pcLowWriteData = 8'h00, tablePointerLow = 8'h00, aluOperandA = 8'h00, aluOperandB = 8'h00;
   logic [5:0]  tablePointerHigh = 6'h00;
   logic [13:0] intVector = 14'h0004;
   logic [15:0] progData;
   logic [13:0] pc, progAddr, p, a;
   logic [13:0] pv [17];
   logic [7:0]  tableLowData, table_high_latch, aluResult, h;
   logic        issueReady, dummyCycle, intAck, stackFull, stackEmpty, tableLowValid, aluCarry;
   int          bad_count = 0, samples_checked = 0;
   always #5 mclk = ~mclk;
   pft_prog_mem memU (.progAddr(progAddr), .progData(progData));
   pft_program_flow dut_u (
      .mclk(mclk), .reset(reset), .opJump(ops[6]), .opCall(ops[5]), .opReturn(ops[4]),
      .opSkipTaken(ops[3]), .opPcLowWrite(ops[2]), .opTableRead(ops[1]), .opAlu(ops[0]),
      .tableMode(tableMode), .jumpOffset(jumpOffset), .bankPointer(bankPointer),
      .pcLowWriteData(pcLowWriteData), .tablePointerLow(tablePointerLow), .tablePointerHigh(tablePointerHigh),
      .aluSubtract(aluSubtract), .aluOperandA(aluOperandA), .aluOperandB(aluOperandB),
      .intRequest(intRequest), .intVector(intVector), .progData(progData), .pc(pc), .progAddr(progAddr),
      .issueReady(issueReady), .dummyCycle(dummyCycle), .intAck(intAck), .stackFull(stackFull),
      .stackEmpty(stackEmpty), .tableLowData(tableLowData), .tableLowValid(tableLowValid),
      .table_high_latch(table_high_latch), .aluResult(aluResult), .aluCarry(aluCarry));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
      end
   endtask
   // Called at a falling edge; the op is taken at the next rising edge and returns at the following falling edge.
   task automatic doOp(input logic [6:0] o);
      ops = o;
      @(negedge mclk);
      ops = 7'h00;
   endtask
   task automatic br(input logic [6:0] o);
      doOp(o);
      chk(dummyCycle, 1'b1);
      chk(issueReady, 1'b0);
      @(negedge mclk);
      chk(dummyCycle, 1'b0);
      chk(issueReady, 1'b1);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      chk(pc, 14'h0000);
      chk(progAddr, 14'h0000);
      chk({stackEmpty, stackFull}, 2'h2);
      doOp(7'h00);
      chk(pc, 14'h0001);
      aluOperandA = 8'hF0;
      aluOperandB = 8'h20;
      doOp(A);
      chk({aluCarry, aluResult}, 9'h110);
      aluOperandA = 8'h10;
      aluSubtract = 1'b1;
      doOp(A);
      chk({aluCarry, aluResult}, 9'h0F0);
      br(S);
      chk(pc, 14'h0005);
      bankPointer = 1'b1;
      jumpOffset = 13'h0345;
      br(J);
      chk(pc, 14'h2345);
      pcLowWriteData = 8'h7E;
      br(W);
      chk(pc, 14'h237E);
      for (int m = 0; m < 3; m++) begin
         tableMode = 2'(m);
         tablePointerLow = 8'h40 + 8'(m);
         tablePointerHigh = 6'h15;
         p = pc;
         a = {(m == 0) ? p[13:8] : (m == 1) ? 6'h15 : 6'h3F, tablePointerLow};
         doOp(T);
         chk(progAddr, a);
         chk({issueReady, pc}, {1'b0, p + 14'h0001});
         @(negedge mclk);
         chk({issueReady, tableLowValid}, 2'h3);
         chk({table_high_latch, tableLowData}, {a[7:0] ^ 8'h3C, a[13:6]});
      end
      h = a[7:0] ^ 8'h3C;
      doOp(A);
      br(J);
      chk(table_high_latch, h);
      for (int i = 0; i < 17; i++) begin
         bankPointer = 1'(i);
         jumpOffset = 13'h0100 + 13'(i * 16);
         pv[i] = pc + 14'h0001;
         br(C);
         chk(pc, {1'(i), jumpOffset});
         chk({stackFull, stackEmpty}, {i >= 15, 1'b0});
      end
      intRequest = 1'b1;
      doOp(7'h00);
      chk({intAck, pc}, {1'b0, {bankPointer, jumpOffset} + 14'h0001});
      br(R);
      chk(pc, pv[16]);
      doOp(7'h00);
      chk({intAck, dummyCycle, pc}, {2'h3, intVector});
      intRequest = 1'b0;
      @(negedge mclk);
      chk(intAck, 1'b0);
      for (int j = 0; j < 16; j++) begin
         br(R);
         chk(pc, pv[16 - j]);
      end
      p = pc;
      br(C);
      br(R);
      chk(pc, p + 14'h0001);
      chk({stackEmpty, stackFull}, 2'h2);
      complete_run();
   end
endmodule
